// *** hw/cmcs_top.sv ***
// Configuration mode select and configuration clock control front end.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
// How it works
// RQ1: Five modes, serial x1/x2/x4, parallel x8/x16; serial capture takes one bit at every width.
// RQ2: Mode comes from two mode-select pins.
// RQ3: Board holds mode pins steady while configuring.
// RQ4: Serial variants share code; parallel variants share.
// RQ5: Master drives clock pin, oscillator or external.
// RQ6: Default master clock rate is 2 MHz.
// RQ7: Start near 1 MHz, then bitstream rate.
// RQ8: Oscillator stops after load unless needed.
// RQ9: Clock pin no pull-up; user pin afterwards.
// RQ10: Slave modes take clock from the host.
// RQ11: Master mode runs the load itself.
// RQ12: Parallel slave has chip select and direction.
// RQ13: Serial slave uses clock and one data.
// RQ14: JTAG path is always available.
// RQ15: Borrowed pins released after configuration ends; the code keeps them borrowed in DONE while CMCS_OPT_KEEP is set.
// RQ16: Mode sampled once per configuration start.
module cmcs_top
  import cmcs_pkg::*;
#(
  parameter int unsigned SYS_MHZ = CMCS_SYS_MHZ
) (
  input  wire logic               ref_clk,
  input  wire logic               reset,
  input  wire logic [1:0]         modeSelect,
  input  wire logic               externalMasterClockIn,
  input  wire logic               configClockPinIn,
  input  wire logic               serialDataIn,
  input  wire logic [15:0]        parallelDataIn,
  input  wire logic               chipSelect_n,
  input  wire logic               readWrite_n,
  input  wire cmcs_pkg::cmcs_bus_s bus,
  output logic [31:0]             rdData,
  output logic                    configClockPinOut,
  output logic                    configClockPinOe_n,
  output logic                    configClockPullUp,
  output logic                    oscillatorEnable,
  output logic                    oscillatorClockOut,
  output logic                    pinsBorrowed,
  output logic                    jtagPathEnable,
  output logic [15:0]             cfgData,
  output logic                    cfgDataValid
);
  import cmcs_pkg::*;

  // ***************************************************************
  // Input synchronisers
  // ***************************************************************
  logic [1:0] modeSync1_q, modeSync2_q;
  logic [2:1] clkSync1_q, clkSync2_q;
  logic [17:0] datSync1_q, datSync2_q;
  logic       clkPinPrev_q, extClkPrev_q;

  always_ff @(posedge ref_clk) begin
    modeSync1_q <= modeSelect;
    modeSync2_q <= modeSync1_q;
    clkSync1_q  <= {configClockPinIn, externalMasterClockIn};
    clkSync2_q  <= clkSync1_q;
    datSync1_q  <= {chipSelect_n, readWrite_n, parallelDataIn};
    datSync2_q  <= datSync1_q;
    clkPinPrev_q <= clkSync2_q[2];
    extClkPrev_q <= clkSync2_q[1];
  end

  logic serSync1_q, serSync2_q;
  always_ff @(posedge ref_clk) begin
    serSync1_q <= serialDataIn;
    serSync2_q <= serSync1_q;
  end

  wire hostClkRise = clkSync2_q[2] & ~clkPinPrev_q;
  wire extClkRise  = clkSync2_q[1] & ~extClkPrev_q;

  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [7:0] rate_q;
  logic [6:0] option_q;
  logic [1:0] width_q;
  logic       rateTaken_q;

  wire wrCtrl = bus.wr && bus.addr == CMCS_REG_CTRL;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rate_q   <= CMCS_RATE_DEFAULT; // RQ6
      option_q <= '0;
      width_q  <= '0;
    end else if (bus.wr) begin
      case (bus.addr)
        CMCS_REG_RATE:   rate_q <= (bus.wdata[7:0] == 8'h00) ?
                                   CMCS_RATE_DEFAULT : bus.wdata[7:0];
        CMCS_REG_OPTION: option_q <= bus.wdata[6:0];
        CMCS_REG_CTRL:   width_q <= bus.wdata[CMCS_CTRL_WIDTH +: 2];
        default: ;
      endcase
    end
  end

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  cmcs_state_e state_q;
  cmcs_mode_e  mode_q;
  logic [1:0]  modeWidth_q;

  wire isMaster = (mode_q == CMCS_MODE_MSERIAL) ||
                  (mode_q == CMCS_MODE_MPAR); // RQ4

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q     <= CMCS_IDLE;
      mode_q      <= CMCS_MODE_MSERIAL;
      modeWidth_q <= '0;
    end else begin
      case (state_q)
        CMCS_IDLE: if (wrCtrl && bus.wdata[CMCS_CTRL_START]) begin
          // Mode is latched once so a late pin change cannot
          // corrupt a load in progress.
          mode_q      <= cmcs_mode_e'(modeSync2_q); // RQ2 RQ16 RQ3
          modeWidth_q <= bus.wdata[CMCS_CTRL_WIDTH +: 2]; // RQ1
          state_q     <= CMCS_LOAD;
        end
        CMCS_LOAD: if (wrCtrl && bus.wdata[CMCS_CTRL_FINISH])
          state_q <= CMCS_DONE;
        CMCS_DONE: if (wrCtrl && bus.wdata[CMCS_CTRL_START]) begin
          mode_q      <= cmcs_mode_e'(modeSync2_q); // RQ16
          modeWidth_q <= bus.wdata[CMCS_CTRL_WIDTH +: 2];
          state_q     <= CMCS_LOAD;
        end
        default: state_q <= CMCS_IDLE;
      endcase
    end
  end

  wire loading = (state_q == CMCS_LOAD);

  always_ff @(posedge ref_clk) begin
    if (reset || !loading)
      rateTaken_q <= 1'b0;
    else if (wrCtrl && bus.wdata[CMCS_CTRL_RATEOK])
      rateTaken_q <= 1'b1; // RQ7
  end

  // ***************************************************************
  // Master clock divider
  // ***************************************************************
  logic [7:0] divCnt_q;
  logic       mclk_q;
  logic [7:0] activeMhz;
  logic [7:0] halfCount;
  assign activeMhz = rateTaken_q ? rate_q : CMCS_RATE_START; // RQ7
  assign halfCount = 8'((SYS_MHZ / 2) / activeMhz);

  wire useExt = option_q[CMCS_OPT_EXTCLK];
  wire divTick = (divCnt_q + 8'h01 >= halfCount);

  always_ff @(posedge ref_clk) begin
    if (reset || !loading || !isMaster) begin
      divCnt_q <= '0;
      mclk_q   <= 1'b0;
    end else if (useExt) begin
      divCnt_q <= '0;
      mclk_q   <= clkSync2_q[1]; // RQ5
    end else if (divTick) begin
      divCnt_q <= '0;
      mclk_q   <= ~mclk_q; // RQ5
    end else begin
      divCnt_q <= divCnt_q + 8'h01;
    end
  end

  wire mclkRise = useExt ? extClkRise : (divTick && !mclk_q);

  // ***************************************************************
  // Data capture
  // ***************************************************************
  // Far side data pass the same two flip-flops as its clock, so a master
  // half period must span at least four system cycles; faster rates would
  // take a word before it has settled at the synchroniser output.
  wire capStrobe = isMaster ? mclkRise : hostClkRise; // RQ10 RQ11
  wire parMode   = (mode_q == CMCS_MODE_MPAR) ||
                   (mode_q == CMCS_MODE_SPAR);
  wire slvParOk  = (mode_q != CMCS_MODE_SPAR) ||
                   (!datSync2_q[17] && !datSync2_q[16]); // RQ12

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfgData      <= '0;
      cfgDataValid <= 1'b0;
    end else begin
      cfgDataValid <= loading && capStrobe && slvParOk;
      if (loading && capStrobe && slvParOk) begin
        if (parMode)
          cfgData <= (modeWidth_q == CMCS_W16) ? datSync2_q[15:0] :
                     {8'h00, datSync2_q[7:0]}; // RQ1
        else
          cfgData <= {15'h0, serSync2_q}; // RQ13
      end
    end
  end

  // ***************************************************************
  // Pins and oscillator
  // ***************************************************************
  wire keepPins = option_q[CMCS_OPT_KEEP];
  wire oscNeeded = option_q[CMCS_OPT_UPSET] | option_q[CMCS_OPT_OSCOUT] |
                   option_q[CMCS_OPT_CRYPT] |
                   (option_q[CMCS_OPT_SUSPEND] & option_q[CMCS_OPT_WAKEUP]);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      configClockPinOut  <= 1'b0;
      configClockPinOe_n <= 1'b1;
      oscillatorEnable   <= 1'b1;
      pinsBorrowed       <= 1'b0;
      oscillatorClockOut <= 1'b0;
    end else begin
      configClockPinOut  <= mclk_q;
      configClockPinOe_n <= !(loading && isMaster); // RQ5 RQ10
      oscillatorEnable   <= (state_q != CMCS_DONE) || oscNeeded; // RQ8
      pinsBorrowed       <= loading ||
                            (state_q == CMCS_DONE && keepPins); // RQ15 RQ9
      oscillatorClockOut <= option_q[CMCS_OPT_OSCOUT] & mclk_q;
    end
  end

  assign configClockPullUp = 1'b0; // RQ9
  assign jtagPathEnable    = 1'b1; // RQ14

  // ***************************************************************
  // Read port
  // ***************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset)
      rdData <= '0;
    else if (bus.rd) begin
      case (bus.addr)
        CMCS_REG_CTRL:   rdData <= {26'h0, width_q, 4'h0};
        CMCS_REG_RATE:   rdData <= {24'h00_0000, rate_q};
        CMCS_REG_OPTION: rdData <= {25'h000_0000, option_q};
        CMCS_REG_STATUS: rdData <= {24'h00_0000, rateTaken_q,
                                    modeWidth_q, mode_q, state_q, isMaster};
        default:         rdData <= '0;
      endcase
    end else
      rdData <= '0;
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  start_rate_a: // RQ7
    assert property (@(posedge ref_clk) disable iff (reset)
    loading && !rateTaken_q |-> activeMhz == CMCS_RATE_START)
    else $error("Start rate not used.");
  pin_drive_a: // RQ5
    assert property (@(posedge ref_clk) disable iff (reset)
    loading && isMaster |=> !configClockPinOe_n)
    else $error("Master not driving clock pin.");
  slave_pin_a: // RQ10
    assert property (@(posedge ref_clk) disable iff (reset)
    !isMaster |=> configClockPinOe_n)
    else $error("Slave drove clock pin.");
  osc_off_a: // RQ8
    assert property (@(posedge ref_clk) disable iff (reset)
    state_q == CMCS_DONE && !oscNeeded |=> !oscillatorEnable)
    else $error("Oscillator left on.");
  osc_load_a: // RQ8
    assert property (@(posedge ref_clk) disable iff (reset)
    loading |=> oscillatorEnable)
    else $error("Oscillator off during load.");
  pin_release_a: // RQ15
    assert property (@(posedge ref_clk) disable iff (reset)
    state_q == CMCS_DONE && !keepPins |=> !pinsBorrowed)
    else $error("Pins not released.");
  pin_borrow_a: // RQ15
    assert property (@(posedge ref_clk) disable iff (reset)
    loading |=> pinsBorrowed)
    else $error("Pins not borrowed during load.");
  pin_keep_a: // RQ9
    assert property (@(posedge ref_clk) disable iff (reset)
    state_q == CMCS_DONE && keepPins |=> pinsBorrowed)
    else $error("Kept pins were released.");
  mode_hold_a: // RQ16
    assert property (@(posedge ref_clk) disable iff (reset)
    loading && $past(loading) |-> $stable(mode_q))
    else $error("Mode changed during load.");
  jtag_on_a: // RQ14
    assert property (@(posedge ref_clk) disable iff (reset)
    jtagPathEnable)
    else $error("JTAG path disabled.");
  default_rate_a: // RQ6
    assert property (@(posedge ref_clk)
    $past(reset) |-> rate_q == CMCS_RATE_DEFAULT)
    else $error("Default rate wrong.");
  no_pull_a: // RQ9
    assert property (@(posedge ref_clk) disable iff (reset)
    !configClockPullUp)
    else $error("Pull-up enabled.");
  spar_gate_a: // RQ12
    assert property (@(posedge ref_clk) disable iff (reset)
    cfgDataValid && mode_q == CMCS_MODE_SPAR |-> $past(slvParOk))
    else $error("Data taken without select.");
  data_gate_a: // RQ11
    assert property (@(posedge ref_clk) disable iff (reset)
    cfgDataValid |-> $past(loading))
    else $error("Data taken outside a load.");

  load_c: cover property (@(posedge ref_clk) state_q == CMCS_LOAD);
  done_c: cover property (@(posedge ref_clk) state_q == CMCS_DONE);
  rate_c: cover property (@(posedge ref_clk) rateTaken_q);
  data_c: cover property (@(posedge ref_clk) cfgDataValid);
  ext_c:  cover property (@(posedge ref_clk) loading && useExt && mclkRise);

endmodule : cmcs_top

// *** hw/cmcs_pkg.sv ***
// Package with constants and types for the configuration mode and clock front end.
package cmcs_pkg;

  // ***************************************************************
  // Mode-select encodings
  // ***************************************************************
  typedef enum logic [1:0] {
    CMCS_MODE_MSERIAL = 2'h0,
    CMCS_MODE_MPAR    = 2'h1,
    CMCS_MODE_SPAR    = 2'h2,
    CMCS_MODE_SSERIAL = 2'h3
  } cmcs_mode_e;

  // Serial and parallel widths reuse the same two-bit codes, so they are
  // plain constants; an enum would refuse the repeated values.
  localparam logic [1:0] CMCS_W1  = 2'h0;
  localparam logic [1:0] CMCS_W2  = 2'h1;
  localparam logic [1:0] CMCS_W4  = 2'h2;
  localparam logic [1:0] CMCS_W8  = 2'h0;
  localparam logic [1:0] CMCS_W16 = 2'h1;

  // ***************************************************************
  // Sequencer states, Gray coded along the usual path
  // ***************************************************************
  typedef enum logic [1:0] {
    CMCS_IDLE = 2'b00,
    CMCS_LOAD = 2'b01,
    CMCS_DONE = 2'b11
  } cmcs_state_e;

  // ***************************************************************
  // Clock rates and register layout
  // ***************************************************************
  localparam int unsigned CMCS_SYS_MHZ      = 125;
  localparam int unsigned CMCS_START_MHZ    = 1;
  localparam int unsigned CMCS_DEFAULT_MHZ  = 2;
  localparam logic [7:0]  CMCS_RATE_DEFAULT = 8'h02;
  localparam logic [7:0]  CMCS_RATE_START   = 8'h01;

  localparam logic [3:0] CMCS_REG_CTRL   = 4'h0;
  localparam logic [3:0] CMCS_REG_RATE   = 4'h1;
  localparam logic [3:0] CMCS_REG_OPTION = 4'h2;
  localparam logic [3:0] CMCS_REG_STATUS = 4'h3;

  // Control register bits.
  localparam int unsigned CMCS_CTRL_START  = 0;
  localparam int unsigned CMCS_CTRL_FINISH = 1;
  localparam int unsigned CMCS_CTRL_RATEOK = 2;
  localparam int unsigned CMCS_CTRL_WIDTH  = 4;

  // Option register bits.
  localparam int unsigned CMCS_OPT_EXTCLK  = 0;
  localparam int unsigned CMCS_OPT_UPSET   = 1;
  localparam int unsigned CMCS_OPT_OSCOUT  = 2;
  localparam int unsigned CMCS_OPT_SUSPEND = 3;
  localparam int unsigned CMCS_OPT_CRYPT   = 4;
  localparam int unsigned CMCS_OPT_KEEP    = 5;
  localparam int unsigned CMCS_OPT_WAKEUP  = 6;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cmcs_bus_s;

  typedef struct packed {
    logic configClockOut;
    logic configClockOe_n;
    logic oscEnable;
    logic pinsBorrowed;
  } cmcs_pins_s;

endpackage : cmcs_pkg

// *** testbench/cmcs_far_model.sv ***
// Far side model: memory in master modes, host in slave modes.
`timescale 1ns/1ns
module cmcs_far_model (
  input  wire logic        masterClk,
  input  wire logic        masterOe_n,
  input  wire logic        hostRun,
  output logic             hostClk,
  output logic             serialOut,
  output logic [15:0]      parOut
);
  logic active;
  logic seenClk;
  assign active  = hostRun | ~masterOe_n;
  assign seenClk = masterOe_n ? hostClk : masterClk;
  initial begin
    hostClk   = 1'b0;
    serialOut = 1'b0;
    parOut    = 16'h1234;
  end
  // The host clock stands still between frames.
  always #40 hostClk = hostRun & ~hostClk;
  // Data moves on the fall so it is steady at the next rise.
  always @(negedge seenClk) begin
    parOut    <= {parOut[14:0], parOut[15] ^ parOut[13] ^ ~parOut[3]};
    serialOut <= ^parOut;
  end
  // Released lines must not keep showing their last value.
  always @(negedge active) begin
    parOut    <= ~parOut;
    serialOut <= ~serialOut;
  end
endmodule : cmcs_far_model

// *** testbench/cmcs_top_test.sv ***
// Self-checking bench for the configuration mode and clock front end.
`timescale 1ns/1ns
module cmcs_top_test;
  import cmcs_pkg::*;
  logic        ref_clk, reset, extClk, extRun, hostRun, hostClk, serData;
  logic        chipSelect_n, readWrite_n, cco, oe_n, pullUp, oscEn;
  logic        oscOut, borrowed, jtagEn, cfgValid, isM, ext, par16;
  logic [1:0]  modeSelect, m, w;
  logic [6:0]  opt;
  logic [15:0] parData, cfgData;
  logic [31:0] rdData, seed, rd, r;
  cmcs_bus_s   bus;
  int          n_fail, compares, p, c;

  cmcs_top i_cmcs_top (.ref_clk(ref_clk), .reset(reset),
    .modeSelect(modeSelect), .externalMasterClockIn(extClk),
    .configClockPinIn(hostClk), .serialDataIn(serData),
    .parallelDataIn(parData), .chipSelect_n(chipSelect_n),
    .readWrite_n(readWrite_n), .bus(bus), .rdData(rdData),
    .configClockPinOut(cco), .configClockPinOe_n(oe_n),
    .configClockPullUp(pullUp), .oscillatorEnable(oscEn),
    .oscillatorClockOut(oscOut), .pinsBorrowed(borrowed),
    .jtagPathEnable(jtagEn), .cfgData(cfgData), .cfgDataValid(cfgValid));
  cmcs_far_model i_cmcs_far_model (.masterClk(cco), .masterOe_n(oe_n),
    .hostRun(hostRun), .hostClk(hostClk), .serialOut(serData),
    .parOut(parData));

  // ********************
  // Helpers
  // ********************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic int period(input logic [31:0] mhz);
    return 2 * (int'(CMCS_SYS_MHZ / 2) /
                ((mhz == 0) ? int'(CMCS_DEFAULT_MHZ) : int'(mhz)));
  endfunction : period
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus <= '0;
  endtask : wreg
  task rreg(input logic [3:0] a);
    @(posedge ref_clk);
    bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus <= '0;
    #1 rd = rdData;
  endtask : rreg
  task edgeWait(input logic v);
    while (cco !== v && p < 1000) begin
      @(negedge ref_clk);
      p++;
    end
  endtask : edgeWait
  task measure();
    p = 0;
    edgeWait(1'b0);
    edgeWait(1'b1);
    p = 0;
    edgeWait(1'b0);
    edgeWait(1'b1);
  endtask : measure
  task count(input int n);
    c = 0;
    repeat (n) begin
      @(negedge ref_clk);
      if (cfgValid === 1'b1) begin
        c++;
        if (par16)
          chk(32'(cfgData), 32'(w[0] ? parData : parData[7:0]));
      end
    end
  endtask : count
  task conclude();
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  // ********************
  // Clocks and watchdog
  // ********************
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    extClk = 1'b0;
    #3;
    forever #40 extClk = extRun & ~extClk;
  end
  initial begin
    #400000;
    n_fail++;
    conclude();
  end

  // ********************
  // Scenarios
  // ********************
  initial begin
    {reset, extRun, hostRun, chipSelect_n, readWrite_n} = 5'b10011;
    {modeSelect, bus, par16, n_fail, compares} = '0;
    seed = 32'h0000_0043;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk(32'({pullUp, jtagEn, oe_n, oscEn, borrowed}), 32'h0E);
    rreg(4'hF);
    chk(rd, 32'h0000_0000);
    for (int i = 0; i < 5; i++) begin
      m = 2'(i);
      isM = (m < 2);
      ext = (i == 4);
      seed = xs(seed);
      w = (m == 1 || m == 2) ? {1'b0, seed[0]} : 2'(seed % 3);
      opt = {seed[15:10], ext};
      modeSelect <= m;
      repeat (4) @(posedge ref_clk);
      wreg(CMCS_REG_OPTION, 32'(opt));
      wreg(CMCS_REG_CTRL, 32'({w, 4'h1}));
      repeat (4) @(posedge ref_clk);
      rreg(CMCS_REG_STATUS);
      chk(rd, 32'({w, m, 2'b01, isM}));
      @(negedge ref_clk);
      chk(32'({oe_n, borrowed, oscEn}), 32'({~isM, 2'b11}));
      @(posedge ref_clk);
      if (isM) begin
        extRun <= ext;
        measure();
        chk(32'(p), ext ? 32'd10 : 32'(period(CMCS_START_MHZ)));
        if (!ext) begin
          // Rates above 15 leave a half period too short for the capture.
          r = (i == 0) ? 32'd0 : 32'd3 + seed[20:16] % 13;
          wreg(CMCS_REG_RATE, r);
          wreg(CMCS_REG_CTRL, 32'({w, 4'h4}));
          measure();
          measure();
          chk(32'(p), 32'(period(r)));
          rreg(CMCS_REG_STATUS);
          chk(32'(rd[7]), 32'd1);
        end
      end else begin
        hostRun <= 1'b1;
        if (m == 2) begin
          count(200);
          chk(32'(c), 32'd0);
          @(posedge ref_clk);
          chipSelect_n <= 1'b0;
          readWrite_n  <= 1'b0;
        end
      end
      par16 = (m == 2'd1 || m == 2'd2);
      count(isM ? 2500 : 400);
      chk(32'(c > 0), 32'd1);
      par16 = 1'b0;
      @(posedge ref_clk);
      {hostRun, extRun, chipSelect_n, readWrite_n} <= 4'b0011;
      wreg(CMCS_REG_CTRL, 32'h0000_0002);
      modeSelect <= ~m;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(32'({borrowed, oscEn}), 32'({opt[5], opt[1] | opt[2] |
          (opt[3] & opt[6]) | opt[4]}));
      if (!opt[5]) chk(32'(oe_n), 32'd1);
      chk(32'({pullUp, jtagEn}), 32'd1);
      rreg(CMCS_REG_STATUS);
      chk(rd, 32'({w, m, 2'b11, isM}));
    end
    conclude();
  end
endmodule : cmcs_top_test
